/* File: pefs_defs.svh */
`ifndef PEFS_DEFS_SVH
`define PEFS_DEFS_SVH

`define PEFS_SEL_OFFSET 12'h000
`define PEFS_STAT_OFFSET 12'h004

`define PEFS_P15_HI 15
`define PEFS_P15_LO 14
`define PEFS_P14 12
`define PEFS_P13 10
`define PEFS_P12 8
`define PEFS_P11 6
`define PEFS_P10 4
`define PEFS_P9 2
`define PEFS_P8 0

`define PEFS_WRITABLE_MASK 16'h_d555
`define PEFS_RESET_NORMAL 16'h_0000
`define PEFS_RESET_HOSTBOOT 16'h_5555

`endif

/* File: pefs_pkg.sv */
`default_nettype none
package pefs_pkg;
  typedef enum logic [1:0] {
    PEFS_P15_PORT = 2'h0,
    PEFS_P15_HOST = 2'h1,
    PEFS_P15_TX = 2'h2,
    PEFS_P15_BAD = 2'h3
  } pefs_p15_mode_t;

  typedef struct packed {
    logic [7:0] port_sel;
    logic [6:0] host_data_sel;
    logic host_chip_select_sel;
    logic serial0_transmit_sel;
    logic [7:0] dir_forced;
    logic [7:0] dir_is_out;
  } pefs_route_t;
endpackage
`default_nettype wire

/* File: pefs_top.sv */
`include "pefs_defs.svh"
`default_nettype none
module pefs_top
  import pefs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic host_boot_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output pefs_route_t route
);
  logic boot_s1_r;
  logic boot_s2_r;
  logic boot_s3_r;
  logic boot_taken_r;
  logic [1:0] boot_cnt_r;
  logic [15:0] sel_r;
  logic [15:0] sel_nxt;
  logic p15_bad_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  pefs_route_t route_r;
  pefs_route_t route_nxt;

  wire setup = psel && !penable;
  // Writes land at the access edge, where the master samples pready
  wire access = psel && penable && pready;
  wire hit_sel = paddr == `PEFS_SEL_OFFSET;
  wire hit_stat = paddr == `PEFS_STAT_OFFSET;
  wire unmapped = !hit_sel && !hit_stat;
  wire wr_sel = access && pwrite && hit_sel;
  wire wr_stat = access && pwrite && hit_stat;
  wire [15:0] boot_reset = boot_s3_r ? `PEFS_RESET_HOSTBOOT : `PEFS_RESET_NORMAL;
  wire [1:0] new_p15 = pwdata[`PEFS_P15_HI:`PEFS_P15_LO];
  // Prohibited code is refused; field keeps its old value
  wire p15_refuse = wr_sel && new_p15 == PEFS_P15_BAD;
  wire [15:0] wr_val = p15_refuse
    ? {sel_r[`PEFS_P15_HI:`PEFS_P15_LO], pwdata[13:0]} : pwdata[15:0];

  function automatic pefs_route_t decode(input logic [15:0] s);
    pefs_route_t r;
    logic [6:0] hd;
    logic [7:0] sel1;
    r = '0;
    hd = {s[`PEFS_P15_HI:`PEFS_P15_LO] == PEFS_P15_HOST, s[`PEFS_P14], s[`PEFS_P13],
          s[`PEFS_P12], s[`PEFS_P11], s[`PEFS_P10], s[`PEFS_P9]};
    r.host_data_sel = hd;
    r.host_chip_select_sel = s[`PEFS_P8];
    r.serial0_transmit_sel = s[`PEFS_P15_HI:`PEFS_P15_LO] == PEFS_P15_TX;
    sel1 = {hd, s[`PEFS_P8]};
    r.port_sel = ~sel1 & {~r.serial0_transmit_sel, 7'h7f};
    // Host data pins: direction left to the host interface
    r.dir_forced = {r.serial0_transmit_sel, 6'h00, s[`PEFS_P8]};
    r.dir_is_out = {r.serial0_transmit_sel, 7'h00};
    return r;
  endfunction

  assign sel_nxt = wr_sel ? (wr_val & `PEFS_WRITABLE_MASK) : sel_r;
  assign route_nxt = decode(sel_nxt);

  // Strap sampled through three stages; register reloads from stage three at each edge until the strap settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_s1_r <= 1'b0;
      boot_s2_r <= 1'b0;
      boot_s3_r <= 1'b0;
    end else begin
      boot_s1_r <= host_boot_mode;
      boot_s2_r <= boot_s1_r;
      boot_s3_r <= boot_s2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_taken_r <= 1'b0;
      boot_cnt_r <= 2'h0;
      sel_r <= `PEFS_RESET_NORMAL;
      route_r <= '0;
      p15_bad_r <= 1'b0;
    end else if (!boot_taken_r) begin
      // Stages hold reset zeros at first; wait until the strap has reached stage three
      if (boot_cnt_r != 2'h3) begin
        boot_cnt_r <= boot_cnt_r + 2'h1;
      end
      boot_taken_r <= (boot_cnt_r == 2'h3) && (boot_s2_r == boot_s3_r);
      sel_r <= boot_reset;
      route_r <= decode(boot_reset);
    end else begin
      sel_r <= sel_nxt;
      route_r <= route_nxt;
      if (p15_refuse) begin
        p15_bad_r <= 1'b1;
      end else if (wr_stat && pwdata[0]) begin
        p15_bad_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= hit_sel ? {16'h0000, sel_r}
                : hit_stat ? {30'h0000_0000, boot_s3_r, p15_bad_r} : 32'h0000_0000;
      pslverr_r <= unmapped;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r;
  assign route = route_r;

endmodule
`default_nettype wire

/* File: pefs_top_props.sv */
`default_nettype none
module pefs_top_props
  import pefs_pkg::*;
(
  input wire logic pclk, presetn, host_boot_mode, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire pefs_route_t route
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  // Code 11 is refused, so only legal writes predict the route
  wire logic wr = psel && !penable && pwrite && paddr == 12'h_000 && pwdata[15:14] != 2'h_3;
  wire logic [6:0] wb = {pwdata[12], pwdata[10], pwdata[8], pwdata[6], pwdata[4], pwdata[2], pwdata[0]};
  chk_zero_wait: assert property (acc |-> pready) else $error("pready low");
  // Route is still cleared at the first edge after reset
  chk_p15_onehot: assert property ($past(presetn) |-> $onehot({route.port_sel[7],
    route.host_data_sel[6], route.serial0_transmit_sel})) else $error("pin15 route bad");
  chk_pins_mid: assert property ($past(presetn) |-> route.port_sel[6:1] == ~route.host_data_sel[5:0])
    else $error("pin9-14 route bad");
  chk_pin8_cs: assert property ($past(presetn) |-> route.port_sel[0] != route.host_chip_select_sel)
    else $error("pin8 route bad");
  chk_wr_route: assert property (wr |-> ##2 route.port_sel[6:0] == ~$past(wb, 2))
    else $error("route lags write");
  chk_wr_tx: assert property (wr |-> ##2 route.serial0_transmit_sel == ($past(pwdata[15:14], 2) == 2'h_2))
    else $error("tx route wrong");
  chk_rsvd_zero: assert property (acc && !pwrite && paddr == 12'h_000 |-> (prdata & 32'h_ffff_2aaa) == 0)
    else $error("reserved bits set");
  chk_tx_dir: assert property (route.serial0_transmit_sel |-> route.dir_forced[7] && route.dir_is_out[7])
    else $error("tx pin not output");
  cover property (wr);
  cover property (route.serial0_transmit_sel);
  cover property (acc && pslverr);
endmodule
bind pefs_top pefs_top_props i_props(.pclk, .presetn, .host_boot_mode, .psel, .penable, .pwrite, .pready,
  .pslverr, .paddr, .pwdata, .prdata, .route);
`default_nettype wire

/* File: port_e_low_pin_function_select_bench.sv */
`default_nettype none
module port_e_low_pin_function_select_bench;
  import pefs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, host_boot_mode = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h_000;
  logic [31:0] pwdata = 0, prdata, rd;
  pefs_route_t route;
  int errors = 0, tests_run = 0;
  // Written value, then value read back; rows[1] tries the prohibited code
  logic [31:0] rows [5] = '{32'h_8000_8000, 32'h_ffff_9555, 32'h_7fff_5555, 32'h_1400_1400, 32'h_0001_0001};
  pefs_top i_dut(.pclk, .presetn, .host_boot_mode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .route);
  initial forever #50 pclk = ~pclk;
  task wrap_up;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      errors++;
      wrap_up;
    end
  endtask
  task do_reset(input logic boot);
    host_boot_mode <= boot;
    presetn <= 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    repeat (10) @(posedge pclk);
  endtask
  initial begin
    do_reset(1);
    apb(0, 0, 0);
    chk(rd, 32'h_0000_5555);
    foreach (rows[i]) begin
      apb(1, 0, {16'h_0000, rows[i][31:16]});
      @(posedge pclk);
      chk(route.serial0_transmit_sel, rows[i][15:14] == 2'h_2);
      apb(0, 0, 0);
      chk(rd, rows[i][15:0]);
    end
    apb(0, 12'h_004, 0);
    chk(rd, 32'h_0000_0003);
    apb(1, 12'h_004, 32'h_0000_0001);
    apb(0, 12'h_004, 0);
    chk(rd, 32'h_0000_0002);
    apb(1, 12'h_008, 32'h_0000_ffff);
    chk(er, 1);
    apb(0, 0, 0);
    chk(rd, 32'h_0000_0001);
    do_reset(0);
    apb(0, 0, 0);
    chk(rd, 32'h_0000_0000);
    wrap_up;
  end
endmodule
`default_nettype wire
